// file: hw/rcr_pkg.sv
// package of constants and carrier types for the reset cause recorder
package rcr_pkg;
   // ----------------------------------------
   // register layout
   // ----------------------------------------
   localparam int RCR_WDT_BIT = 4;
   localparam int RCR_LVD_BIT = 0;
   localparam logic [7:0] RCR_CAUSE_RESET = 8'h00;
   localparam logic [7:0] RCR_LVD_RESET = 8'h00;
   localparam logic [7:0] RCR_IRQ_RESET = 8'h00;
   localparam logic [7:0] RCR_MASK_RESET = 8'hFF;
   localparam logic [7:0] RCR_PRIO_RESET = 8'hFF;
   // watchdog enable reset values chosen by option byte
   localparam logic [7:0] RCR_WATCHDOG_ENABLE_REG_OPT0 = 8'h1A;
   localparam logic [7:0] RCR_WATCHDOG_ENABLE_REG_OPT1 = 8'h9A;
   // power-up clear thresholds in millivolts, for reference
   localparam int RCR_CLEAR_LOW_MV = 1590;
   localparam int RCR_CLEAR_HIGH_MV = 2700;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      RCR_PUC_HOLD = 2'b00,
      RCR_PUC_RUN = 2'b01
   } rcr_puc_state_t;

   typedef struct packed
   {
      logic pin;
      logic wdt;
      logic lvd;
   } rcr_req_t;

   typedef struct packed
   {
      logic [7:0] control;
      logic [7:0] level;
   } rcr_lvd_regs_t;
endpackage

// file: hw/rcr_top.sv
// reset cause recorder with power-up clear and reset-kind dependent initial values
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - during reset the recorder state stays as the reset kind dictates.
// - a cause register remembers which internal sources made internal resets since it was last cleared.
// - the cause register is read as a whole byte by the processor.
// - the cause register becomes zero on pin reset, power-up clear and on a processor read of it with no set in the same cycle.
// - the watchdog flag sets on watchdog reset, holds on low-voltage reset, clears on pin or power-up clear.
// - the low-voltage flag sets on low-voltage reset, holds on watchdog reset, clears on pin or power-up clear.
// - low-voltage control and level registers clear on pin, power-up clear or watchdog reset, held on own reset.
// - the watchdog enable reset value follows an option byte bit.
// - interrupt request registers reset to 00h, mask and priority registers to ffh.
// - power-up clear holds reset at power-on and releases on the low or high comparator by option bit.
// - power-up clear asserts reset whenever supply falls below the low detect level.
// - in dual mode reset stays until the supply reaches the high level.
module rcr_top
   import rcr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_pin_reset,
   input wire logic i_wdt_reset_req,
   input wire logic i_lvd_reset_req,
   input wire logic i_above_low,
   input wire logic i_above_high,
   input wire logic i_supply_threshold_select,
   input wire logic i_watchdog_enable_reg_option,
   input wire logic i_cause_read,
   input wire logic i_lvd_write,
   input wire logic [7:0] i_lvd_control_wdata,
   input wire logic [7:0] i_lvd_level_wdata,
   output logic [7:0] o_reset_cause_flags,
   output logic o_internal_reset,
   output logic o_power_up_clear,
   output logic [7:0] o_lowvolt_detect_control,
   output logic [7:0] o_lowvolt_level_select,
   output logic [7:0] o_watchdog_enable_init,
   output logic [7:0] o_interrupt_request_init,
   output logic [7:0] o_interrupt_mask_init,
   output logic [7:0] o_interrupt_priority_init
);

   // ----------------------------------------
   // power-up clear
   // ----------------------------------------
   rcr_puc_state_t puc_state;
   rcr_puc_state_t next_puc_state;
   logic puc;
   logic next_puc;

   always_comb
   begin
      next_puc_state = puc_state;
      case (puc_state)
         RCR_PUC_HOLD:
         begin
            // release level follows the mode, the fall level never does
            if (i_supply_threshold_select ? i_above_high : i_above_low)
            begin
               next_puc_state = RCR_PUC_RUN;
            end
         end
         RCR_PUC_RUN:
         begin
            if (!i_above_low)
            begin
               next_puc_state = RCR_PUC_HOLD;
            end
         end
         default:
         begin
            next_puc_state = RCR_PUC_HOLD;
         end
      endcase
      next_puc = (next_puc_state == RCR_PUC_HOLD);
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         puc_state <= RCR_PUC_HOLD;
         puc <= 1'b1;
      end
      else
      begin
         puc_state <= next_puc_state;
         puc <= next_puc;
      end
   end

   // ----------------------------------------
   // cause flags and low-voltage registers
   // ----------------------------------------
   rcr_req_t req;
   logic wdt_flag;
   logic lvd_flag;
   logic next_wdt_flag;
   logic next_lvd_flag;
   rcr_lvd_regs_t lvd_regs;
   rcr_lvd_regs_t next_lvd_regs;
   logic [7:0] cause;
   logic [7:0] next_cause;
   logic int_rst;
   logic next_int_rst;

   // low-voltage registers as left by a clearing reset
   function automatic rcr_lvd_regs_t lvd_cleared();
      return '{control: RCR_LVD_RESET, level: RCR_LVD_RESET};
   endfunction

   always_comb
   begin
      req = '{pin: i_pin_reset, wdt: i_wdt_reset_req, lvd: i_lvd_reset_req};
      next_wdt_flag = wdt_flag;
      next_lvd_flag = lvd_flag;
      next_lvd_regs = lvd_regs;
      if (i_cause_read)
      begin
         next_wdt_flag = 1'b0;
         next_lvd_flag = 1'b0;
      end
      if (i_lvd_write)
      begin
         next_lvd_regs = '{control: i_lvd_control_wdata, level: i_lvd_level_wdata};
      end
      // pin reset and power-up clear beat any set in the same cycle
      if (req.pin || puc)
      begin
         next_wdt_flag = 1'b0;
         next_lvd_flag = 1'b0;
         next_lvd_regs = lvd_cleared();
      end
      else
      begin
         // a set beats a read clear in the same cycle
         if (req.wdt)
         begin
            next_wdt_flag = 1'b1;
            // watchdog clear beats a write in the same cycle
            next_lvd_regs = lvd_cleared();
         end
         if (req.lvd)
         begin
            next_lvd_flag = 1'b1;
         end
      end
      next_cause = 8'h00;
      next_cause[RCR_WDT_BIT] = next_wdt_flag;
      next_cause[RCR_LVD_BIT] = next_lvd_flag;
      // internal reset follows every source and the power-up clear
      next_int_rst = next_puc || req.pin || req.wdt || req.lvd;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         wdt_flag <= 1'b0;
         lvd_flag <= 1'b0;
         lvd_regs <= lvd_cleared();
         cause <= RCR_CAUSE_RESET;
         int_rst <= 1'b1;
      end
      else
      begin
         wdt_flag <= next_wdt_flag;
         lvd_flag <= next_lvd_flag;
         lvd_regs <= next_lvd_regs;
         cause <= next_cause;
         int_rst <= next_int_rst;
      end
   end

   // ----------------------------------------
   // reset values for neighbouring registers
   // ----------------------------------------
   logic [7:0] watchdog_enable_reg_init;
   logic [7:0] next_watchdog_enable_reg_init;

   always_comb
   begin
      next_watchdog_enable_reg_init = i_watchdog_enable_reg_option ? RCR_WATCHDOG_ENABLE_REG_OPT1 : RCR_WATCHDOG_ENABLE_REG_OPT0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         // option bit is honoured while reset is held as well
         watchdog_enable_reg_init <= next_watchdog_enable_reg_init;
      end
      else
      begin
         watchdog_enable_reg_init <= next_watchdog_enable_reg_init;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------

   assign o_reset_cause_flags = cause;
   assign o_internal_reset = int_rst;
   assign o_power_up_clear = puc;
   assign o_lowvolt_detect_control = lvd_regs.control;
   assign o_lowvolt_level_select = lvd_regs.level;
   assign o_watchdog_enable_init = watchdog_enable_reg_init;

   always_ff @(posedge i_mclk)
   begin
      // fixed reset values for the interrupt flag registers
      o_interrupt_request_init <= RCR_IRQ_RESET;
      o_interrupt_mask_init <= RCR_MASK_RESET;
      o_interrupt_priority_init <= RCR_PRIO_RESET;
   end

endmodule // rcr_top
`default_nettype wire

// file: verification/rcr_chk.sv
// assertions on the reset cause recorder ports
`timescale 1ns/1ps
`default_nettype none
module rcr_chk
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_pin_reset,
   input wire logic i_wdt_reset_req,
   input wire logic i_lvd_reset_req,
   input wire logic i_above_low,
   input wire logic i_above_high,
   input wire logic i_supply_threshold_select,
   input wire logic i_cause_read,
   input wire logic i_lvd_write,
   input wire logic [7:0] o_reset_cause_flags,
   input wire logic o_power_up_clear,
   input wire logic [7:0] o_lowvolt_detect_control
);
   logic free;
   assign free = !i_pin_reset && !o_power_up_clear && i_above_low;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   property p_wset; free && i_wdt_reset_req |=> o_reset_cause_flags[4]; endproperty
   a_wset: assert property (p_wset) else $error("wdt flag");
   property p_lset; free && i_lvd_reset_req |=> o_reset_cause_flags[0]; endproperty
   a_lset: assert property (p_lset) else $error("lvd flag");
   property p_pin; i_pin_reset |=> o_reset_cause_flags == 8'h00; endproperty
   a_pin: assert property (p_pin) else $error("pin clear");
   property p_rd; i_cause_read && !i_wdt_reset_req && !i_lvd_reset_req |=> !o_reset_cause_flags;
   endproperty
   a_rd: assert property (p_rd) else $error("read clear");
   property p_zero; (o_reset_cause_flags & 8'hee) == 8'h00; endproperty
   a_zero: assert property (p_zero) else $error("spare bits");
   property p_keep;
      free && i_lvd_reset_req && !i_wdt_reset_req && !i_lvd_write |=> $stable(o_lowvolt_detect_control);
   endproperty
   a_keep: assert property (p_keep) else $error("lvd regs lost");
   property p_wclr; i_wdt_reset_req |=> o_lowvolt_detect_control == 8'h00; endproperty
   a_wclr: assert property (p_wclr) else $error("lvd regs kept");
   property p_puc; !i_above_low |=> o_power_up_clear; endproperty
   a_puc: assert property (p_puc) else $error("no clear");
   property p_hold;
      o_power_up_clear && i_supply_threshold_select && !i_above_high |=> o_power_up_clear;
   endproperty
   a_hold: assert property (p_hold) else $error("early release");
   property p_pclr; o_power_up_clear |=> o_reset_cause_flags == 8'h00; endproperty
   a_pclr: assert property (p_pclr) else $error("puc clear");
endmodule // rcr_chk
`default_nettype wire

// file: verification/rcr_supply_model.sv
// supply comparator model feeding the recorder
`timescale 1ns/1ps
`default_nettype none
module rcr_supply_model
   import rcr_pkg::*;
(
   input wire logic [11:0] i_mv,
   output logic o_above_low,
   output logic o_above_high
);
   assign o_above_low = i_mv >= 12'(RCR_CLEAR_LOW_MV);
   assign o_above_high = i_mv >= 12'(RCR_CLEAR_HIGH_MV);
endmodule // rcr_supply_model
`default_nettype wire

// file: verification/rcr_top_bench.sv
// self-checking bench for the reset cause recorder
`timescale 1ns/1ps
`default_nettype none
module rcr_top_bench;
   logic i_mclk = 0, i_srst = 1, i_pin_reset = 0, i_wdt_reset_req = 0, i_lvd_reset_req = 0;
   logic i_supply_threshold_select = 1, i_watchdog_enable_reg_option = 0, i_cause_read = 0, i_lvd_write = 0;
   logic i_above_low, i_above_high, o_internal_reset, o_power_up_clear;
   logic [7:0] i_lvd_control_wdata = 8'h5a, i_lvd_level_wdata = 8'ha5, o_reset_cause_flags;
   logic [7:0] o_lowvolt_detect_control, o_lowvolt_level_select, o_watchdog_enable_init;
   logic [7:0] o_interrupt_request_init, o_interrupt_mask_init, o_interrupt_priority_init;
   logic [11:0] mv = 12'h000;
   int mismatches = 0, check_count = 0;
   always #25 i_mclk = ~i_mclk;
   rcr_supply_model i_rcr_supply_model (.i_mv(mv), .o_above_low(i_above_low),
      .o_above_high(i_above_high));
   rcr_top i_rcr_top (.*);
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      tick(10);
      check(8'(o_power_up_clear), 8'h01);
      check(8'(o_internal_reset), 8'h01);
      i_srst = 0;
      mv = 12'h7d0;
      tick(3);
      check(8'(o_power_up_clear), 8'h01);
      mv = 12'hbb8;
      tick(2);
      check(8'(o_power_up_clear), 8'h00);
      check(o_interrupt_mask_init, 8'hff);
      check(o_interrupt_priority_init, 8'hff);
      check(o_interrupt_request_init, 8'h00);
      check(o_watchdog_enable_init, 8'h1a);
      i_lvd_write = 1;
      tick(1);
      i_lvd_write = 0;
      i_lvd_reset_req = 1;
      tick(1);
      i_lvd_reset_req = 0;
      tick(2);
      check(o_reset_cause_flags, 8'h01);
      check(o_lowvolt_level_select, 8'ha5);
      check(o_lowvolt_detect_control, 8'h5a);
      i_wdt_reset_req = 1;
      tick(1);
      i_wdt_reset_req = 0;
      tick(2);
      check(o_reset_cause_flags, 8'h11);
      check(o_lowvolt_detect_control, 8'h00);
      i_cause_read = 1;
      tick(1);
      i_cause_read = 0;
      check(o_reset_cause_flags, 8'h00);
      i_wdt_reset_req = 1;
      tick(1);
      i_wdt_reset_req = 0;
      i_pin_reset = 1;
      tick(1);
      i_pin_reset = 0;
      check(o_reset_cause_flags, 8'h00);
      i_lvd_reset_req = 1;
      tick(1);
      i_lvd_reset_req = 0;
      mv = 12'h3e8;
      tick(2);
      check(8'(o_power_up_clear), 8'h01);
      check(o_reset_cause_flags, 8'h00);
      mv = 12'hbb8;
      i_watchdog_enable_reg_option = 1;
      tick(3);
      check(8'(o_power_up_clear), 8'h00);
      check(o_watchdog_enable_init, 8'h9a);
      check(8'(o_internal_reset), 8'h00);
      i_supply_threshold_select = 0;
      mv = 12'h3e8;
      tick(2);
      check(8'(o_internal_reset), 8'h01);
      mv = 12'h7d0;
      tick(2);
      check(8'(o_power_up_clear), 8'h00);
      check(8'(o_internal_reset), 8'h00);
      i_wdt_reset_req = 1;
      i_cause_read = 1;
      tick(1);
      i_wdt_reset_req = 0;
      i_cause_read = 0;
      check(o_reset_cause_flags, 8'h10);
      check(8'(o_internal_reset), 8'h01);
      complete_run();
   end
endmodule // rcr_top_bench
bind rcr_top rcr_chk i_rcr_chk (.*);
`default_nettype wire
